// *** aptx_consts.svh ***
// Behaviour
// R1 - lsb-drive bit: full cycle or half then hi-z
// R2 - keeper field: off, on, one, one-and-half cycles
// R3 - offset field delays slot 0 msb 0..31 cycles
// R4 - offset on tdm slot 0, both halves otherwise
// R5 - lsb, keeper, offset apply to both lines
// R6 - chain bit selects shared bus or daisy chain
// R7 - fault-detect-off bit low enables bus fault detection
// R8 - resume after fault unless resume-off bit set
// R9 - line bit routes channel to primary or secondary
// R10 - tdm places channel at its slot 0..63
// R11 - i2s/lj slot 0-31 left, 32-63 right
// R12 - reset: channel 1 slot 0, channel 2 slot 1
// R13 - format field: tdm, i2s, lj, reserved
// R14 - word length 16, 20, 24, 32 bits
// R15 - host captures per slot, line and framing
`ifndef APTX_CONSTS_SVH
`define APTX_CONSTS_SVH
// register addresses
`define APTX_ADDR_FMT 8'h07
`define APTX_ADDR_CFG1 8'h08
`define APTX_ADDR_CFG2 8'h09
`define APTX_ADDR_CH1 8'h0B
`define APTX_ADDR_CH2 8'h0C
// reset values and writable masks
`define APTX_FMT_RST 8'h30
`define APTX_CFG1_RST 8'h00
`define APTX_CFG2_RST 8'h00
`define APTX_CH1_RST 8'h00
`define APTX_CH2_RST 8'h01
`define APTX_CFG2_MASK 8'hB0
`define APTX_CH_MASK 8'h7F
// field positions
`define APTX_F_FMT 7:6
`define APTX_F_WLEN 5:4
`define APTX_F_LSB 7
`define APTX_F_KEEP 6:5
`define APTX_F_OFS 4:0
`define APTX_F_CHAIN 7
`define APTX_F_DETOFF 5
`define APTX_F_RESOFF 4
`define APTX_F_LINE 6
`define APTX_F_SLOT 5:0
// register indices in the crossing bundle
`define APTX_R_FMT 0
`define APTX_R_CFG1 1
`define APTX_R_CFG2 2
`define APTX_R_CH1 3
`define APTX_R_CH2 4
`define APTX_NREG 5
// encodings
`define APTX_FMT_TDM 2'h0
`define APTX_FMT_I2S 2'h1
`define APTX_FMT_LJ 2'h2
`define APTX_KEEP_OFF 2'h0
`define APTX_KEEP_ON 2'h1
`define APTX_KEEP_ONE 2'h2
`define APTX_KEEP_ONEHALF 2'h3
// last bit index per word length, last slot index, fifo depth and width
`define APTX_WL16_LAST 5'h0F
`define APTX_WL20_LAST 5'h13
`define APTX_WL24_LAST 5'h17
`define APTX_WL32_LAST 5'h1F
`define APTX_SLOT_LAST 6'h3F
`define APTX_FIFO_DEPTH 32
`define APTX_FIFO_WIDTH 64
`endif

// *** aptx_pkg.sv ***
`include "aptx_consts.svh"
package aptx_pkg;
    // transmit run state, gray along run-halt-wait
    typedef enum logic [1:0] {
        APTX_RUN = 2'b00,
        APTX_HALT = 2'b01,
        APTX_WAIT = 2'b11
    } aptx_state_t;
    typedef logic [`APTX_NREG-1:0][7:0] aptx_regs_t;
endpackage

// *** aptx_fifo.sv ***
`timescale 1ns/100ps
`include "aptx_consts.svh"
module aptx_fifo #(
    parameter int WIDTH = `APTX_FIFO_WIDTH,
    parameter int DEPTH = `APTX_FIFO_DEPTH
) (
    input wire logic clk_in, // core clock
    input wire logic rst_n_in, // sync reset
    input wire logic in_valid_in, // write request
    output logic in_ready_out, // not full
    input wire logic [WIDTH-1:0] in_data_in, // write word
    output logic out_valid_out, // not empty
    input wire logic out_ready_in, // pop
    output logic [WIDTH-1:0] out_data_out // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic push, pop;

    // honest flags from pointers
    assign in_ready_out = !((wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
    assign out_valid_out = (wp_ff != rp_ff);
    assign out_data_out = mem_ff[rp_ff[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // pointer update
    always_comb begin
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data_in;
        end
    end
endmodule

// *** aptx_top.sv ***
`timescale 1ns/100ps
`include "aptx_consts.svh"
module aptx_top
    import aptx_pkg::*;
(
    input wire logic clk_in, // core clock 25 MHz
    input wire logic rst_n_in, // sync reset
    input wire logic [7:0] reg_addr_in, // control port address
    input wire logic [7:0] reg_wdata_in, // write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [7:0] reg_rdata_out, // read data, next cycle
    input wire logic samp_valid_in, // sample pair valid
    output logic samp_ready_out, // fifo has room
    input wire logic [31:0] samp_ch1_in, // channel 1 sample, msb aligned
    input wire logic [31:0] samp_ch2_in, // channel 2 sample, msb aligned
    input wire logic bit_clk_in, // link bit clock
    input wire logic frame_sync_in, // frame sync pin
    input wire logic chain_data_in, // upstream chain data
    output logic primary_serial_out, // primary data
    output logic primary_serial_oe_out, // primary drive enable
    output logic general_pin_one_out, // secondary data
    output logic general_pin_one_oe_out, // secondary drive enable
    output logic [1:0] keeper_en_out, // keeper per line
    output logic bus_fault_out, // bus fault level
    output logic tx_halted_out // transmit halted
);
    // core domain state
    aptx_regs_t regs_ff, nxt_regs;
    aptx_state_t state_ff, nxt_state;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [63:0] shadow_ff, nxt_shadow;
    logic rq1_ff, rq2_ff, rq3_ff, ft1_ff, ft2_ff;
    logic fifo_valid, fifo_pop, req_edge;
    logic [63:0] fifo_data;
    // link domain state
    aptx_regs_t cs1_ff, csa_ff, csb_ff, cs2_ff;
    logic hl1_ff, hl2_ff, rs1_ff, brst_n;
    logic fs1_ff, fs2_ff, fs3_ff, dc1_ff, dc2_ff;
    logic [5:0] wait_ff, nxt_wait, slot_ff, nxt_slot;
    logic [4:0] bit_ff, nxt_bit, wl_last;
    logic act_ff, nxt_act, half_ff, nxt_half, req_ff, nxt_req;
    logic [1:0][31:0] words_ff, nxt_words;
    logic [11:0] len_ff, nxt_len, prev_ff, nxt_prev;
    logic fault_ff, nxt_fault, pos_t_ff, neg_t_ff;
    logic [1:0] data_ff, nxt_data, oe_ff, nxt_oe, lsb_ff, nxt_lsb, lsbp_ff;
    logic fs_rise, fs_fall, half_start, half_sel, emit, first_half;
    logic [1:0] ch_on, ch_bit, ch_line;
    logic [1:0] b_fmt, b_keep;
    logic [4:0] b_ofs;
    logic cfg_wr;

    assign cfg_wr = reg_wr_in && (reg_addr_in == `APTX_ADDR_FMT || reg_addr_in == `APTX_ADDR_CFG1
        || reg_addr_in == `APTX_ADDR_CFG2 || reg_addr_in == `APTX_ADDR_CH1 || reg_addr_in == `APTX_ADDR_CH2);
    assign req_edge = rq2_ff ^ rq3_ff;
    assign fifo_pop = req_edge && (state_ff == APTX_RUN);

    aptx_fifo #(
        .WIDTH(`APTX_FIFO_WIDTH),
        .DEPTH(`APTX_FIFO_DEPTH)
    ) aptx_fifo_inst (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(samp_valid_in),
        .in_ready_out(samp_ready_out),
        .in_data_in({samp_ch2_in, samp_ch1_in}),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    // register file, read data, halt state, frame word hand-off
    always_comb begin
        nxt_regs = regs_ff;
        nxt_rdata = rdata_ff;
        nxt_state = state_ff;
        nxt_shadow = shadow_ff;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `APTX_ADDR_FMT: nxt_regs[`APTX_R_FMT] = reg_wdata_in; // R13 R14
                `APTX_ADDR_CFG1: nxt_regs[`APTX_R_CFG1] = reg_wdata_in; // R1 R2 R3
                `APTX_ADDR_CFG2: nxt_regs[`APTX_R_CFG2] = reg_wdata_in & `APTX_CFG2_MASK; // R6 R7
                `APTX_ADDR_CH1: nxt_regs[`APTX_R_CH1] = reg_wdata_in & `APTX_CH_MASK; // R9 R10
                `APTX_ADDR_CH2: nxt_regs[`APTX_R_CH2] = reg_wdata_in & `APTX_CH_MASK;
                default: nxt_regs = regs_ff;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                `APTX_ADDR_FMT: nxt_rdata = regs_ff[`APTX_R_FMT];
                `APTX_ADDR_CFG1: nxt_rdata = regs_ff[`APTX_R_CFG1];
                `APTX_ADDR_CFG2: nxt_rdata = regs_ff[`APTX_R_CFG2];
                `APTX_ADDR_CH1: nxt_rdata = regs_ff[`APTX_R_CH1];
                `APTX_ADDR_CH2: nxt_rdata = regs_ff[`APTX_R_CH2];
                default: nxt_rdata = 8'h00;
            endcase
        end
        // fault halts; resume-off waits for a host write
        case (state_ff)
            APTX_RUN: begin
                if (ft2_ff) nxt_state = APTX_HALT; // R8
            end
            APTX_HALT: begin
                if (!ft2_ff) begin
                    nxt_state = regs_ff[`APTX_R_CFG2][`APTX_F_RESOFF] ? APTX_WAIT : APTX_RUN; // R8
                end
            end
            APTX_WAIT: begin
                if (cfg_wr) nxt_state = APTX_RUN; // R8
            end
            default: nxt_state = APTX_RUN;
        endcase
        // empty fifo or halt sends silence
        if (req_edge) begin
            nxt_shadow = fifo_pop && fifo_valid ? fifo_data : 64'h0000000000000000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            regs_ff[`APTX_R_FMT] <= `APTX_FMT_RST;
            regs_ff[`APTX_R_CFG1] <= `APTX_CFG1_RST;
            regs_ff[`APTX_R_CFG2] <= `APTX_CFG2_RST;
            regs_ff[`APTX_R_CH1] <= `APTX_CH1_RST; // R12
            regs_ff[`APTX_R_CH2] <= `APTX_CH2_RST; // R12
            rdata_ff <= 8'h00;
            state_ff <= APTX_RUN;
            shadow_ff <= 64'h0000000000000000;
        end else begin
            regs_ff <= nxt_regs;
            rdata_ff <= nxt_rdata;
            state_ff <= nxt_state;
            shadow_ff <= nxt_shadow;
        end
    end

    // link-to-core synchronisers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            {rq1_ff, rq2_ff, rq3_ff, ft1_ff, ft2_ff} <= 5'h00;
        end else begin
            {rq1_ff, rq2_ff, rq3_ff} <= {req_ff, rq1_ff, rq2_ff};
            {ft1_ff, ft2_ff} <= {fault_ff, ft1_ff};
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign bus_fault_out = ft2_ff;
    assign tx_halted_out = (state_ff != APTX_RUN);

    // link reset and core-to-link synchronisers
    always_ff @(posedge bit_clk_in) begin
        rs1_ff <= rst_n_in;
        brst_n <= rs1_ff;
        cs1_ff <= regs_ff;
        csa_ff <= cs1_ff;
        csb_ff <= csa_ff;
        // settled copy: a torn word never agrees with its neighbour sample
        cs2_ff <= (csa_ff == csb_ff) ? csb_ff : cs2_ff;
        hl1_ff <= tx_halted_out;
        hl2_ff <= hl1_ff;
        {fs1_ff, fs2_ff, fs3_ff} <= {frame_sync_in, fs1_ff, fs2_ff};
        {dc1_ff, dc2_ff} <= {chain_data_in, dc1_ff};
    end

    assign b_fmt = cs2_ff[`APTX_R_FMT][`APTX_F_FMT];
    assign b_keep = cs2_ff[`APTX_R_CFG1][`APTX_F_KEEP];
    assign b_ofs = cs2_ff[`APTX_R_CFG1][`APTX_F_OFS];
    assign fs_rise = fs2_ff && !fs3_ff;
    assign fs_fall = !fs2_ff && fs3_ff;
    assign emit = act_ff && (wait_ff == 6'h00);
    assign first_half = pos_t_ff ^ neg_t_ff;

    // word length to last bit index
    always_comb begin
        case (cs2_ff[`APTX_R_FMT][`APTX_F_WLEN]) // R14
            2'h0: wl_last = `APTX_WL16_LAST;
            2'h1: wl_last = `APTX_WL20_LAST;
            2'h2: wl_last = `APTX_WL24_LAST;
            default: wl_last = `APTX_WL32_LAST;
        endcase
    end

    // per-channel slot match and bit pick
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic [7:0] chr;
            assign chr = cs2_ff[`APTX_R_CH1 + c];
            assign ch_line[c] = chr[`APTX_F_LINE];
            assign ch_bit[c] = words_ff[c][5'h1F - bit_ff];
            assign ch_on[c] = emit && ((b_fmt == `APTX_FMT_TDM) ? (chr[`APTX_F_SLOT] == slot_ff) // R10
                : (b_fmt != 2'h3) && !slot_ff[5] && (chr[`APTX_F_SLOT] == {half_ff, slot_ff[4:0]})); // R11
        end
    endgenerate

    // framing sequencer, fault check, line drivers
    always_comb begin
        nxt_wait = wait_ff;
        nxt_act = act_ff;
        nxt_bit = bit_ff;
        nxt_slot = slot_ff;
        nxt_half = half_ff;
        nxt_words = words_ff;
        nxt_req = req_ff;
        // counting starts at the first frame edge, so a cut first frame is never compared
        nxt_len = (len_ff == 12'h000) ? 12'h000 : len_ff + 12'h001;
        nxt_prev = prev_ff;
        nxt_fault = fault_ff && !cs2_ff[`APTX_R_CFG2][`APTX_F_DETOFF];
        case (b_fmt) // R13
            `APTX_FMT_TDM: begin
                half_start = fs_rise;
                half_sel = 1'b0;
            end
            `APTX_FMT_I2S: begin
                half_start = fs_rise || fs_fall;
                half_sel = fs_rise;
            end
            `APTX_FMT_LJ: begin
                half_start = fs_rise || fs_fall;
                half_sel = fs_fall;
            end
            default: begin
                half_start = 1'b0;
                half_sel = 1'b0;
            end
        endcase
        if (fs_rise) begin
            nxt_len = 12'h001;
            nxt_prev = len_ff;
            nxt_req = !req_ff;
            nxt_words = shadow_ff;
            if (prev_ff != 12'h000) begin
                nxt_fault = !cs2_ff[`APTX_R_CFG2][`APTX_F_DETOFF] && (prev_ff != len_ff); // R7
            end
        end
        if (half_start) begin
            nxt_wait = {1'b0, b_ofs} + {5'h00, b_fmt == `APTX_FMT_I2S}; // R3 R4
            nxt_act = 1'b1;
            nxt_bit = 5'h00;
            nxt_slot = 6'h00;
            nxt_half = half_sel;
        end else if (act_ff && !emit) begin
            nxt_wait = wait_ff - 6'h01;
        end else if (emit) begin
            if (bit_ff == wl_last) begin
                nxt_bit = 5'h00;
                if (slot_ff == `APTX_SLOT_LAST) nxt_act = 1'b0;
                else nxt_slot = slot_ff + 6'h01;
            end else begin
                nxt_bit = bit_ff + 5'h01;
            end
        end
        for (int l = 0; l < 2; l++) begin
            logic h0, h1;
            h0 = ch_on[0] && (ch_line[0] == l[0]); // R9
            h1 = ch_on[1] && (ch_line[1] == l[0]);
            nxt_data[l] = h0 ? ch_bit[0] : (h1 ? ch_bit[1] : (l == 0) && dc2_ff);
            nxt_oe[l] = !hl2_ff && (h0 || h1 || ((l == 0) && cs2_ff[`APTX_R_CFG2][`APTX_F_CHAIN])); // R6
            nxt_lsb[l] = (h0 || h1) && (bit_ff == wl_last); // R5
        end
    end

    always_ff @(posedge bit_clk_in) begin
        if (!brst_n) begin
            {wait_ff, slot_ff, bit_ff} <= 17'h00000;
            {act_ff, half_ff, req_ff, fault_ff, pos_t_ff} <= 5'h00;
            words_ff <= 64'h0000000000000000;
            {len_ff, prev_ff} <= 24'h000000;
            {data_ff, oe_ff, lsb_ff, lsbp_ff} <= 8'h00;
        end else begin
            {wait_ff, slot_ff, bit_ff} <= {nxt_wait, nxt_slot, nxt_bit};
            {act_ff, half_ff, req_ff, fault_ff} <= {nxt_act, nxt_half, nxt_req, nxt_fault};
            pos_t_ff <= !pos_t_ff;
            words_ff <= nxt_words;
            {len_ff, prev_ff} <= {nxt_len, nxt_prev};
            {data_ff, oe_ff, lsb_ff, lsbp_ff} <= {nxt_data, nxt_oe, nxt_lsb, lsb_ff};
        end
    end

    // half-cycle marker on the falling edge
    always_ff @(negedge bit_clk_in) begin
        if (!brst_n) neg_t_ff <= 1'b0;
        else neg_t_ff <= pos_t_ff;
    end

    // pin drive, lsb release and keeper per line
    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_line
            logic cut;
            assign cut = lsb_ff[k] && cs2_ff[`APTX_R_CFG1][`APTX_F_LSB] && !first_half; // R1
            assign keeper_en_out[k] = (b_keep == `APTX_KEEP_ON) // R2
                || (b_keep[1] && lsb_ff[k])
                || ((b_keep == `APTX_KEEP_ONEHALF) && lsbp_ff[k] && first_half);
        end
    endgenerate

    assign primary_serial_out = data_ff[0];
    assign primary_serial_oe_out = oe_ff[0] && !g_line[0].cut; // R5
    assign general_pin_one_out = data_ff[1];
    assign general_pin_one_oe_out = oe_ff[1] && !g_line[1].cut;

    // core-domain checks
    chk_reset_slots: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
        $past(!rst_n_in) |-> regs_ff[`APTX_R_CH2] == `APTX_CH2_RST && regs_ff[`APTX_R_CH1] == `APTX_CH1_RST)
        else $error("slot defaults wrong after reset");
    chk_fault_halts: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        state_ff == APTX_RUN && ft2_ff |=> tx_halted_out)
        else $error("fault did not halt transmit");
    chk_auto_resume: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        state_ff == APTX_HALT && !ft2_ff && !regs_ff[`APTX_R_CFG2][`APTX_F_RESOFF] |=> state_ff == APTX_RUN)
        else $error("auto resume failed");
    chk_resume_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        state_ff == APTX_WAIT && !cfg_wr |=> state_ff == APTX_WAIT)
        else $error("left wait without host write");
    chk_cfg2_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
        reg_wr_in && reg_addr_in == `APTX_ADDR_CFG2 |=> regs_ff[`APTX_R_CFG2] == ($past(reg_wdata_in) & `APTX_CFG2_MASK))
        else $error("cfg2 write mismatch");
    // link-domain checks
    chk_offset_load: assert property (@(posedge bit_clk_in) disable iff (!brst_n) // R3
        half_start && b_fmt == `APTX_FMT_TDM |=> wait_ff == {1'b0, $past(b_ofs)})
        else $error("offset not loaded");
    chk_detect_off: assert property (@(posedge bit_clk_in) disable iff (!brst_n) // R7
        cs2_ff[`APTX_R_CFG2][`APTX_F_DETOFF] |=> !fault_ff)
        else $error("fault raised while detection off");
    chk_lsb_mark: assert property (@(posedge bit_clk_in) disable iff (!brst_n) // R1
        ch_on[0] && !ch_line[0] && bit_ff == wl_last |=> lsb_ff[0])
        else $error("lsb not marked");
    chk_tdm_slot: assert property (@(posedge bit_clk_in) disable iff (!brst_n) // R10
        emit && b_fmt == `APTX_FMT_TDM && !hl2_ff && !cs2_ff[`APTX_R_CH1][`APTX_F_LINE]
        && cs2_ff[`APTX_R_CH1][`APTX_F_SLOT] == slot_ff |=> oe_ff[0])
        else $error("assigned slot not driven");
    chk_keeper_off: assert property (@(posedge bit_clk_in) disable iff (!brst_n) // R2
        b_keep == `APTX_KEEP_OFF |-> keeper_en_out == 2'h0)
        else $error("keeper on while disabled");
    cov_halt: cover property (@(posedge clk_in) disable iff (!rst_n_in) state_ff == APTX_HALT);
    cov_wait: cover property (@(posedge clk_in) disable iff (!rst_n_in) state_ff == APTX_WAIT ##1 state_ff == APTX_RUN);
    cov_lsb_cut: cover property (@(posedge bit_clk_in) disable iff (!brst_n) g_line[0].cut && oe_ff[0]);
    cov_right_half: cover property (@(posedge bit_clk_in) disable iff (!brst_n) ch_on[1] && half_ff);
endmodule

// *** aptx_host_model.sv ***
`timescale 1ns/100ps
module aptx_host_model (
    output logic bit_clk_out, // link bit clock
    output logic frame_sync_out, // high in first half of frame
    output logic chain_data_out, // upstream chain data, toggles
    input wire logic [5:0] pins_in // keepers, sec oe/data, pri oe/data
);
    logic [5:0] cap [0:4095]; // pin states per bit of last frame
    logic chn [0:4095]; // upstream chain level per bit
    // idle levels; the clock stands still between run_frames calls
    initial begin
        bit_clk_out = 1'b0;
        frame_sync_out = 1'b0;
        chain_data_out = 1'b0;
    end
    // back to back frames, lines sampled at three quarters of each bit
    task automatic run_frames(input int n, input int len);
        #1.3;
        for (int f = 0; f < n; f++) begin
            for (int i = 0; i < len; i++) begin
                bit_clk_out = 1'b1;
                #6;
                bit_clk_out = 1'b0;
                frame_sync_out = (i < len / 2);
                chain_data_out = ~chain_data_out;
                #3;
                cap[i] = pins_in;
                chn[i] = chain_data_out;
                #3;
            end
        end
    endtask
endmodule

// *** aptx_top_test.sv ***
`timescale 1ns/100ps
`include "aptx_consts.svh"
module aptx_top_test;
    import aptx_pkg::*;
    localparam int LAT = 4; // bit clocks from frame sync pin edge to msb
    localparam int LIMIT = 90000; // cycle ceiling against a hang
    logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, samp_valid_in, samp_ready_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [31:0] samp_ch1_in, samp_ch2_in;
    logic bit_clk, frame_sync, chain_data, pri_d, pri_oe, sec_d, sec_oe, bus_fault_out, tx_halted_out;
    logic [1:0] keeper_en_out, fmt, wl, keepm;
    logic [4:0] ofs;
    logic lsbh, chain;
    logic [5:0] slot [2];
    logic line [2];
    logic [31:0] smp [2];
    int errors, num_checks, cycles, len;

    aptx_top aptx_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .samp_valid_in(samp_valid_in), .samp_ready_out(samp_ready_out),
        .samp_ch1_in(samp_ch1_in), .samp_ch2_in(samp_ch2_in), .bit_clk_in(bit_clk),
        .frame_sync_in(frame_sync), .chain_data_in(chain_data), .primary_serial_out(pri_d),
        .primary_serial_oe_out(pri_oe), .general_pin_one_out(sec_d), .general_pin_one_oe_out(sec_oe),
        .keeper_en_out(keeper_en_out), .bus_fault_out(bus_fault_out), .tx_halted_out(tx_halted_out));
    aptx_host_model aptx_host_model_inst (.bit_clk_out(bit_clk), .frame_sync_out(frame_sync),
        .chain_data_out(chain_data), .pins_in({keeper_en_out, sec_oe, sec_d, pri_oe, pri_d}));

    // core clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (e !== s) begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", what, e, s);
        end
    endtask

    // reset with the link clock running so the link side resets too
    task automatic do_reset();
        fork
            aptx_host_model_inst.run_frames(1, 64);
            begin
                @(posedge clk_in);
                rst_n_in <= 1'b0;
                repeat (4) @(posedge clk_in);
                rst_n_in <= 1'b1;
            end
        join
        @(posedge clk_in);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask

    // offer the same pair for 40 cycles; counts taken pairs
    task automatic fill(output int n);
        logic r;
        n = 0;
        @(posedge clk_in);
        samp_ch1_in <= smp[0];
        samp_ch2_in <= smp[1];
        samp_valid_in <= 1'b1;
        repeat (40) begin
            @(negedge clk_in);
            r = samp_ready_out;
            @(posedge clk_in);
            n += int'(r === 1'b1);
        end
        samp_valid_in <= 1'b0;
    endtask

    // expected {owned, keeper, enable, data} of one line at bit i
    function automatic logic [3:0] exp_bit(input int i, input int ln);
        logic [3:0] r;
        int w, st, b;
        w = (wl == 2'h3) ? 32 : 16 + 4 * int'(wl);
        // daisy data lags three bits, the chain toggles every bit
        r = {chain && ln == 0, keepm == `APTX_KEEP_ON, chain && ln == 0, !aptx_host_model_inst.chn[i]};
        if (fmt == 2'h3) return 4'h0;
        for (int c = 0; c < 2; c++) begin
            st = LAT + ofs + ((fmt == `APTX_FMT_TDM) ? int'(slot[c]) : int'(slot[c][4:0])) * w;
            if (fmt != `APTX_FMT_TDM) st += int'(fmt == `APTX_FMT_I2S) + ((slot[c][5] ^ (fmt == `APTX_FMT_I2S)) ? len / 2 : 0);
            b = i - st;
            if (line[c] == ln && b >= 0 && b < w) begin
                r[3] = 1'b1;
                r[1] = !(lsbh && b == w - 1);
                r[0] = smp[c][31 - b];
                r[2] = r[2] | (keepm[1] && b == w - 1);
            end
        end
        return r;
    endfunction

    task automatic check_frame();
        logic [3:0] e;
        logic [5:0] p;
        for (int i = 0; i < len; i++) begin
            p = aptx_host_model_inst.cap[i];
            for (int ln = 0; ln < 2; ln++) begin
                e = exp_bit(i, ln);
                chk("line bit", 32'({e[3] & e[0], e[2:1]}), 32'({e[3] & p[2 * ln], p[4 + ln], p[2 * ln + 1]}));
            end
        end
    endtask

    initial begin
        int n;
        logic [7:0] d;
        static logic [7:0] adr [5] = '{`APTX_ADDR_FMT, `APTX_ADDR_CFG1, `APTX_ADDR_CFG2, `APTX_ADDR_CH1, `APTX_ADDR_CH2};
        static logic [7:0] rv [5] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h01};
        static logic [7:0] mk [5] = '{8'hFF, 8'hFF, 8'hB0, 8'h7F, 8'h7F};
        {rst_n_in, reg_wr_in, reg_rd_in, samp_valid_in, reg_addr_in, reg_wdata_in} = '0;
        {samp_ch1_in, samp_ch2_in} = '0;
        void'($urandom(4028));
        do_reset();
        // reset values, reserved bits, unmapped place
        for (int k = 0; k < 5; k++) begin
            reg_rd(adr[k], d);
            chk("reset value", 32'(rv[k]), 32'(d));
            reg_wr(adr[k], 8'hFF);
            reg_rd(adr[k], d);
            chk("written value", 32'(mk[k]), 32'(d));
        end
        reg_wr(8'h0A, 8'h5A);
        reg_rd(8'h0A, d);
        chk("unmapped read", 32'h0, 32'(d));
        $display("test registers done");
        // framing configurations, random with corners
        for (int k = 0; k < 10; k++) begin
            fmt = (k == 9) ? 2'h3 : 2'(k % 3);
            wl = 2'(k % 4);
            keepm = (k == 9) ? 2'h0 : 2'(k % 4);
            ofs = (k == 1) ? 5'h1F : 5'($urandom_range(31, 0));
            chain = (k == 8);
            lsbh = !chain && $urandom_range(1, 0);
            slot[0] = (k == 0) ? 6'h3F : 6'($urandom_range(63, 0));
            slot[1] = slot[0] ^ 6'h01;
            for (int c = 0; c < 2; c++) begin
                line[c] = 1'($urandom_range(1, 0));
                smp[c] = $urandom();
            end
            len = 64 * ((wl == 2'h3) ? 32 : 16 + 4 * int'(wl)) + 128;
            do_reset();
            reg_wr(`APTX_ADDR_FMT, {fmt, wl, 4'h0});
            reg_wr(`APTX_ADDR_CFG1, {lsbh, keepm, ofs});
            reg_wr(`APTX_ADDR_CFG2, {chain, 1'b0, 1'b1, 5'h00});
            reg_wr(`APTX_ADDR_CH1, {1'b0, line[0], slot[0]});
            reg_wr(`APTX_ADDR_CH2, {1'b0, line[1], slot[1]});
            fill(n);
            chk("accepted pairs", 32, 32'(n));
            aptx_host_model_inst.run_frames(3, len);
            check_frame(); // frame layout
            if (k == 4) begin
                aptx_host_model_inst.run_frames(33, len);
                smp[0] = 32'h0;
                smp[1] = 32'h0;
                check_frame(); // empty buffer sends zeros
            end
            $display("test frame %0d done", k);
        end
        // frame length fault: detect and resume, detect and hold, detect off
        for (int m = 0; m < 3; m++) begin
            do_reset();
            reg_wr(`APTX_ADDR_CFG2, 8'h00);
            aptx_host_model_inst.run_frames(4, 128);
            reg_wr(`APTX_ADDR_CFG2, (m == 1) ? 8'h10 : (m == 2) ? 8'h20 : 8'h00);
            aptx_host_model_inst.run_frames(1, 136);
            aptx_host_model_inst.run_frames(1, 128);
            repeat (10) @(negedge clk_in);
            chk("fault raised", 32'(m != 2), 32'(bus_fault_out));
            chk("halted", 32'(m != 2), 32'(tx_halted_out));
            aptx_host_model_inst.run_frames(2, 128);
            repeat (10) @(negedge clk_in);
            chk("fault cleared", 32'h0, 32'(bus_fault_out));
            chk("stays halted", 32'(m == 1), 32'(tx_halted_out));
            reg_wr(`APTX_ADDR_FMT, 8'h30);
            repeat (10) @(negedge clk_in);
            chk("resumed", 32'h0, 32'(tx_halted_out));
            $display("test fault %0d done", m);
        end
        give_verdict();
    end
endmodule
